// file: design/flash_host_pkg.sv
// Package: constants and carrier types for the sector flash host controller
package flash_host_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CLK_NS = 25;
   localparam int unsigned ADDR_W = 19;
   localparam int unsigned SECTOR_BYTES = 256;
   // Key addresses and data bytes
   localparam logic [18:0] KEY_ADDR_A = 19'h05555;
   localparam logic [18:0] KEY_ADDR_B = 19'h02aaa;
   localparam logic [7:0] KEY_DATA_A = 8'haa;
   localparam logic [7:0] KEY_DATA_B = 8'h55;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_IDENT_EXIT = 8'hf0;
   localparam logic [18:0] ADDR_MAKER = 19'h00000;
   localparam logic [18:0] ADDR_PART = 19'h00001;
   localparam logic [18:0] ADDR_BOOT_LO = 19'h00002;
   localparam logic [18:0] ADDR_BOOT_HI = 19'h7fff2;
   localparam int unsigned TOGGLE_BIT = 6;
   // Timing in its own units, then cycles
   localparam int unsigned IDENT_WAIT_MS = 20;
   localparam int unsigned IDENT_WAIT_CYC = IDENT_WAIT_MS * (CLK_HZ / 1000);
   localparam int unsigned BYTE_LOAD_WINDOW_US = 150;
   localparam int unsigned BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * (CLK_HZ / 1_000_000);
   localparam int unsigned PROGRAM_CYCLE_TIME_MS = 20;
   localparam int unsigned STROBE_NS = 200;
   localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned READ_NS = 250;
   localparam int unsigned READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RESET_CNT = 4'h0;
   // User commands
   typedef enum logic [1:0] {OP_READ, OP_IDENT, OP_IDENT_EXIT, OP_PROGRAM} op_t;
   typedef struct packed {
      op_t op;
      logic [18:0] addr;
   } cmd_t;
   typedef struct packed {
      logic [7:0] data;
      logic [18:0] addr;
   } ans_t;
endpackage : flash_host_pkg

// file: design/flash_host.sv
// Host controller driving a sector flash through its parallel pins
`timescale 1ns/1ps
module flash_host #(
   parameter int unsigned IDENT_WAIT = flash_host_pkg::IDENT_WAIT_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // User command stream
   input wire logic i_cmd_valid,
   input wire flash_host_pkg::cmd_t i_cmd,
   output logic o_cmd_ready,
   // Program data stream, 256 bytes per program command
   input wire logic i_wdata_valid,
   input wire logic [7:0] i_wdata,
   output logic o_wdata_ready,
   // Read answer stream
   output logic o_ans_valid,
   output flash_host_pkg::ans_t o_ans,
   input wire logic i_ans_ready,
   // Status
   output logic o_busy,
   output logic o_load_late,
   // Flash pins
   output logic o_ce_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic [18:0] o_addr,
   output logic [7:0] o_dq,
   output logic o_dq_oe_n,
   input wire logic [7:0] i_dq
);
   typedef enum {S_IDLE, S_KEY, S_WAIT_ID, S_LOAD, S_POLL, S_READ, S_PUSH} state_t;
   state_t state_q;
   flash_host_pkg::op_t op_q;
   logic [18:0] addr_q;
   logic [1:0] key_q;
   logic [8:0] cnt_b_q;
   logic [23:0] wait_q;
   logic [4:0] ph_q;
   logic [7:0] dq_s1_q, dq_s2_q;
   logic tog_have_q, tog_q;
   logic [7:0] rd_q;
   // Two-entry answer buffer
   flash_host_pkg::ans_t buf_q [2];
   logic wr_q, rd_ptr_q;
   logic [1:0] cnt_q;
   logic push;

   function automatic logic [18:0] key_addr(input logic [1:0] k);
      return (k == 2'd1) ? flash_host_pkg::KEY_ADDR_B : flash_host_pkg::KEY_ADDR_A;
   endfunction : key_addr
   function automatic logic [7:0] key_data(input logic [1:0] k, input flash_host_pkg::op_t op);
      if (k == 2'd0) begin
         return flash_host_pkg::KEY_DATA_A;
      end
      if (k == 2'd1) begin
         return flash_host_pkg::KEY_DATA_B;
      end
      return (op == flash_host_pkg::OP_IDENT) ? flash_host_pkg::CMD_IDENT :
             (op == flash_host_pkg::OP_PROGRAM) ? flash_host_pkg::CMD_PROGRAM : flash_host_pkg::CMD_IDENT_EXIT;
   endfunction : key_data

   // Pin data is asynchronous to i_clk
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         dq_s1_q <= 8'h00;
         dq_s2_q <= 8'h00;
      end else begin
         dq_s1_q <= i_dq;
         dq_s2_q <= dq_s1_q;
      end
   end

   assign push = (state_q == S_PUSH) && (cnt_q != 2'd2);

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         wr_q <= 1'b0;
         rd_ptr_q <= 1'b0;
         cnt_q <= 2'd0;
         o_ans_valid <= 1'b0;
         o_ans <= '0;
      end else begin
         if (push) begin
            buf_q[wr_q] <= '{data: rd_q, addr: addr_q};
            wr_q <= ~wr_q;
         end
         if (o_ans_valid && i_ans_ready) begin
            rd_ptr_q <= ~rd_ptr_q;
         end
         cnt_q <= cnt_q + 2'(push) - 2'(o_ans_valid && i_ans_ready);
         // Registered head view keeps the output straight from a flop
         if (!o_ans_valid || i_ans_ready) begin
            o_ans_valid <= (cnt_q - 2'(o_ans_valid && i_ans_ready)) != 2'd0 || push;
            if ((cnt_q - 2'(o_ans_valid && i_ans_ready)) != 2'd0) begin
               o_ans <= buf_q[rd_ptr_q ^ (o_ans_valid && i_ans_ready)];
            end else begin
               o_ans <= '{data: rd_q, addr: addr_q};
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_q <= S_IDLE;
         op_q <= flash_host_pkg::OP_READ;
         addr_q <= '0;
         key_q <= 2'd0;
         cnt_b_q <= '0;
         wait_q <= '0;
         ph_q <= 5'(flash_host_pkg::RESET_CNT);
         tog_have_q <= 1'b0;
         tog_q <= 1'b0;
         rd_q <= 8'h00;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_addr <= '0;
         o_dq <= 8'h00;
         o_dq_oe_n <= 1'b1;
         o_cmd_ready <= 1'b0;
         o_wdata_ready <= 1'b0;
         o_busy <= 1'b0;
         o_load_late <= 1'b0;
      end else begin
         o_wdata_ready <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               o_busy <= 1'b0;
               o_cmd_ready <= 1'b1;
               if (i_cmd_valid && o_cmd_ready) begin
                  o_cmd_ready <= 1'b0;
                  o_busy <= 1'b1;
                  op_q <= i_cmd.op;
                  addr_q <= i_cmd.addr;
                  key_q <= 2'd0;
                  ph_q <= '0;
                  state_q <= (i_cmd.op == flash_host_pkg::OP_READ) ? S_READ : S_KEY;
               end
            end
            S_KEY: begin
               // Keyed write on the low address bits only
               ph_q <= ph_q + 5'd1;
               o_ce_n <= 1'b0;
               o_addr <= key_addr(key_q);
               o_dq <= key_data(key_q, op_q);
               o_dq_oe_n <= 1'b0;
               o_we_n <= !(ph_q >= 5'd1 && ph_q <= 5'(flash_host_pkg::STROBE_CYC));
               if (ph_q == 5'(2 * flash_host_pkg::STROBE_CYC)) begin
                  ph_q <= '0;
                  key_q <= key_q + 2'd1;
                  if (key_q == 2'd2) begin
                     o_ce_n <= 1'b1;
                     o_dq_oe_n <= 1'b1;
                     wait_q <= '0;
                     cnt_b_q <= '0;
                     o_load_late <= 1'b0;
                     state_q <= (op_q == flash_host_pkg::OP_PROGRAM) ? S_LOAD : S_WAIT_ID;
                  end
               end
            end
            S_WAIT_ID: begin
               // Mode settles before any read is allowed
               wait_q <= wait_q + 24'd1;
               if (wait_q == 24'(IDENT_WAIT - 1)) begin
                  state_q <= S_IDLE;
               end
            end
            S_LOAD: begin
               // Same sector bits every byte, low byte counts up
               wait_q <= wait_q + 24'd1;
               if (wait_q == 24'(flash_host_pkg::BYTE_LOAD_WINDOW_CYC - 1)) begin
                  o_load_late <= 1'b1;
               end
               if (ph_q == 5'd0) begin
                  o_wdata_ready <= !o_wdata_ready;
                  if (i_wdata_valid && o_wdata_ready) begin
                     o_wdata_ready <= 1'b0;
                     o_dq <= i_wdata;
                     o_addr <= {addr_q[18:8], cnt_b_q[7:0]};
                     o_ce_n <= 1'b0;
                     o_dq_oe_n <= 1'b0;
                     ph_q <= 5'd1;
                  end
               end else begin
                  ph_q <= ph_q + 5'd1;
                  o_we_n <= !(ph_q <= 5'(flash_host_pkg::STROBE_CYC));
                  if (ph_q == 5'(2 * flash_host_pkg::STROBE_CYC)) begin
                     ph_q <= '0;
                     wait_q <= '0;
                     cnt_b_q <= cnt_b_q + 9'd1;
                     if (cnt_b_q == 9'(flash_host_pkg::SECTOR_BYTES - 1)) begin
                        o_ce_n <= 1'b1;
                        o_dq_oe_n <= 1'b1;
                        tog_have_q <= 1'b0;
                        state_q <= S_POLL;
                     end
                  end
               end
            end
            S_POLL: begin
               // Fixed address; only a change of the toggle bit matters
               ph_q <= ph_q + 5'd1;
               o_ce_n <= 1'b0;
               o_oe_n <= !(ph_q < 5'(flash_host_pkg::READ_CYC));
               if (ph_q == 5'(flash_host_pkg::READ_CYC + 2)) begin
                  ph_q <= '0;
                  tog_have_q <= 1'b1;
                  tog_q <= dq_s2_q[flash_host_pkg::TOGGLE_BIT];
                  if (tog_have_q && tog_q == dq_s2_q[flash_host_pkg::TOGGLE_BIT]) begin
                     o_ce_n <= 1'b1;
                     o_oe_n <= 1'b1;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_READ: begin
               // Plain read; also fetches codes and boot state
               ph_q <= ph_q + 5'd1;
               o_ce_n <= 1'b0;
               o_addr <= addr_q;
               o_oe_n <= !(ph_q < 5'(flash_host_pkg::READ_CYC + 2));
               if (ph_q == 5'(flash_host_pkg::READ_CYC + 2)) begin
                  rd_q <= dq_s2_q;
                  o_ce_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  state_q <= S_PUSH;
               end
            end
            S_PUSH: begin
               // Stall here while the answer buffer is full
               if (push) begin
                  state_q <= S_IDLE;
               end
            end
         endcase
      end
   end

   // Key writes checked at the falling strobe; the device latches them at the rising strobe
   a_key_we_width: assert property (@(posedge i_clk) disable iff (i_reset)
      $fell(o_we_n) |-> !o_we_n [*8] ##1 o_we_n) else $error("write strobe width wrong");
   a_key_first: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_KEY && $fell(o_we_n) && key_q == 2'd0) |->
      o_addr == flash_host_pkg::KEY_ADDR_A && o_dq == flash_host_pkg::KEY_DATA_A)
      else $error("first key wrong");
   a_key_order: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_KEY && $fell(o_we_n) && key_q == 2'd1) |-> o_addr == 19'h02aaa && o_dq == 8'h55)
      else $error("second key wrong");
   a_key_third: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_KEY && $fell(o_we_n) && key_q == 2'd2) |-> o_addr == 19'h05555 &&
      o_dq == ((op_q == flash_host_pkg::OP_PROGRAM) ? 8'ha0 : (op_q == flash_host_pkg::OP_IDENT) ? 8'h90 : 8'hf0))
      else $error("third key wrong");
   a_write_drive: assert property (@(posedge i_clk) disable iff (i_reset)
      !o_we_n |-> !o_ce_n && !o_dq_oe_n && o_oe_n) else $error("write strobe without data drive");
   a_load_sector: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_LOAD && $fell(o_we_n)) |-> o_addr[18:8] == addr_q[18:8]) else $error("sector moved");
   a_load_count: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_LOAD && $fell(o_we_n)) |-> o_addr[7:0] == cnt_b_q[7:0]) else $error("byte order broken");
   a_oe_we_excl: assert property (@(posedge i_clk) disable iff (i_reset)
      !(~o_oe_n && ~o_we_n)) else $error("read and write strobes together");
   a_poll_addr: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_POLL && $past(state_q) == S_POLL) |-> $stable(o_addr)) else $error("poll address moved");
   a_poll_release: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_POLL) |-> o_dq_oe_n && o_we_n) else $error("data driven while polling");
   a_no_cmd_busy: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_POLL) |-> !o_cmd_ready && o_we_n) else $error("command during program");
   a_ident_wait: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_WAIT_ID) |-> o_ce_n && !o_cmd_ready) else $error("access during mode wait");
   a_late_flag: assert property (@(posedge i_clk) disable iff (i_reset)
      (state_q == S_LOAD && wait_q == 24'd6000) |=> o_load_late) else $error("late load not flagged");
   a_ans_hold: assert property (@(posedge i_clk) disable iff (i_reset)
      (o_ans_valid && !i_ans_ready) |=> o_ans_valid && $stable(o_ans)) else $error("answer dropped while stalled");
   a_ready_idle: assert property (@(posedge i_clk) disable iff (i_reset)
      o_cmd_ready |-> !o_busy) else $error("command offered while busy");
   // Main scenarios
   c_program: cover property (@(posedge i_clk) state_q == S_POLL ##1 state_q == S_IDLE);
   c_ident: cover property (@(posedge i_clk) state_q == S_WAIT_ID ##1 state_q == S_IDLE);
   c_buf_full: cover property (@(posedge i_clk) cnt_q == 2'd2);
   c_late: cover property (@(posedge i_clk) $rose(o_load_late));
   c_exit: cover property (@(posedge i_clk) state_q == S_KEY && op_q == flash_host_pkg::OP_IDENT_EXIT ##1
      state_q == S_WAIT_ID);
endmodule : flash_host

// file: tb/flash_dev_model.sv
// Behavioural model of the sector flash device
`timescale 1ns/1ps
module flash_dev_model #(
   parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value
   parameter int unsigned IDENT_NS = 1250,
   parameter int unsigned PROG_NS = 20000,
   parameter int unsigned LOAD_NS = 150000
) (
   // Flash pins
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [18:0] i_addr,
   input wire logic [7:0] i_dq,
   output logic [7:0] o_dq
);
   logic [7:0] mem [int];
   logic [7:0] rd_val;
   logic [7:0] last_q = 8'h00;
   logic ident = 1'b0; // Powers up in normal reads
   logic busy = 1'b0;
   logic loading = 1'b0;
   logic tog = 1'b0;
   logic [10:0] sect;
   logic [18:0] poll_addr;
   int kst = 0;
   int nbytes = 0;
   int bad = 0;
   int toggles = 0;
   int early = 0;
   int late = 0;
   realtime t_ident = 0.0;
   realtime t_load = 0.0;
   wire rd_on = !i_ce_n && !i_oe_n;
   // Writes while programming are dropped, like the real part
   always @(posedge i_we_n) begin
      if (!i_ce_n && !busy) begin
         if (loading && nbytes > 0 && $realtime - t_load > LOAD_NS) begin
            // Gap past the load window starts programming; the late byte is lost
            late++;
            loading = 1'b0;
            toggles = 0;
            busy = 1'b1;
            busy <= #(PROG_NS) 1'b0;
         end else if (loading) begin
            if (nbytes == 0) sect = i_addr[18:8];
            if (i_addr[18:8] !== sect) bad++;
            mem[i_addr] = i_dq;
            nbytes++;
            t_load = $realtime;
            if (nbytes == 256) begin
               loading = 1'b0;
               toggles = 0;
               busy = 1'b1;
               busy <= #(PROG_NS) 1'b0;
            end
         end else if (kst == 0) kst = (i_addr[14:0] == 15'h5555 && i_dq == 8'haa) ? 1 : 0;
         else if (kst == 1) kst = (i_addr[14:0] == 15'h2aaa && i_dq == 8'h55) ? 2 : 0;
         else begin
            kst = 0;
            if (i_addr[14:0] == 15'h5555 && i_dq == 8'h90) begin
               ident = 1'b1;
               t_ident = $realtime;
            end
            if (i_addr[14:0] == 15'h5555 && i_dq == 8'hf0) ident = 1'b0;
            if (i_addr[14:0] == 15'h5555 && i_dq == 8'ha0) begin
               loading = 1'b1;
               nbytes = 0;
            end
         end
      end
   end
   // One event per read, so a joint fall of both strobes toggles once
   always @(posedge rd_on) begin
      if (busy) begin
         tog = ~tog;
         if (toggles > 0 && i_addr !== poll_addr) bad++;
         toggles++;
         poll_addr = i_addr;
      end
      if (ident && $realtime - t_ident < IDENT_NS) early++;
   end
   always @(i_addr or busy or tog or ident or rd_on) begin
      if (busy) rd_val = {1'b0, tog, 6'h00};
      else if (ident && i_addr[18:1] == 18'h0) rd_val = i_addr[0] ? PART_CODE : MAKER_CODE;
      else if (ident && (i_addr == 19'h00002 || i_addr == 19'h7fff2)) rd_val = 8'hfe; // Never locked
      else rd_val = mem.exists(i_addr) ? mem[i_addr] : 8'hxx; // Unloaded bytes unknown
   end
   // Released lines show the inverse so stale data never passes
   always @(negedge rd_on) last_q = ~rd_val;
   assign o_dq = rd_on ? rd_val : last_q;
endmodule : flash_dev_model

// file: tb/flash_host_tb_top.sv
// Self-checking bench for the sector flash host controller
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, (a), (e)); end end
module flash_host_tb_top;
   localparam int LIMIT = 40000;
   logic clk, reset, cmd_valid, wdata_valid, ans_ready;
   flash_host_pkg::cmd_t cmd;
   flash_host_pkg::ans_t ans;
   logic [7:0] wdata, h_dq, dev_dq;
   logic cmd_ready, wdata_ready, ans_valid, busy, load_late, ce_n, oe_n, we_n, dq_oe_n;
   logic [18:0] addr;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   wire [7:0] dq_bus = !dq_oe_n ? h_dq : dev_dq;
   flash_host #(.IDENT_WAIT(50)) u_flash_host (.i_clk(clk), .i_reset(reset), .i_cmd_valid(cmd_valid),
      .i_cmd(cmd), .o_cmd_ready(cmd_ready), .i_wdata_valid(wdata_valid), .i_wdata(wdata),
      .o_wdata_ready(wdata_ready), .o_ans_valid(ans_valid), .o_ans(ans), .i_ans_ready(ans_ready),
      .o_busy(busy), .o_load_late(load_late), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
      .o_addr(addr), .o_dq(h_dq), .o_dq_oe_n(dq_oe_n), .i_dq(dq_bus));
   flash_dev_model #(.IDENT_NS(1250), .PROG_NS(20000)) u_flash_dev_model (.i_ce_n(ce_n), .i_oe_n(oe_n),
      .i_we_n(we_n), .i_addr(addr), .i_dq(dq_bus), .o_dq(dev_dq));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         test_done();
      end
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic send(input flash_host_pkg::op_t op, input logic [18:0] a);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd = '{op, a};
      while (cmd_ready !== 1'b1 && n < LIMIT) begin
         step();
         n++;
      end
      step();
      cmd_valid = 1'b0;
      step();
   endtask : send
   task automatic take(input logic [18:0] a, input logic [7:0] d);
      int n;
      n = 0;
      while (ans_valid !== 1'b1 && n < 200) begin
         step();
         n++;
      end
      `CHK(ans.addr, a)
      `CHK(ans.data, d)
      ans_ready = 1'b1;
      step();
      ans_ready = 1'b0;
      step();
   endtask : take
   task automatic read(input logic [18:0] a, input logic [7:0] d);
      send(flash_host_pkg::OP_READ, a);
      take(a, d);
   endtask : read
   task automatic idle_wait();
      int n;
      n = 0;
      while ((busy !== 1'b0 || cmd_ready !== 1'b1) && n < LIMIT) begin
         step();
         n++;
      end
   endtask : idle_wait
   task automatic t_ident();
      send(flash_host_pkg::OP_IDENT, 19'h00000);
      read(19'h00000, u_flash_dev_model.MAKER_CODE);
      `CHK(u_flash_dev_model.ident, 1'b1)
      read(19'h00001, u_flash_dev_model.PART_CODE);
      read(19'h00002, 8'hfe);
      read(19'h7fff2, 8'hfe);
      `CHK(u_flash_dev_model.early, 0)
      send(flash_host_pkg::OP_IDENT_EXIT, 19'h00000);
      idle_wait();
      `CHK(u_flash_dev_model.ident, 1'b0)
   endtask : t_ident
   task automatic t_program(input logic [10:0] s);
      int n;
      int k;
      send(flash_host_pkg::OP_PROGRAM, {s, 8'h00});
      wdata_valid = 1'b1;
      for (k = 0; k < 256; k++) begin
         wdata = k[7:0] ^ s[7:0];
         n = 0;
         while (wdata_ready !== 1'b1 && n < 1000) begin
            step();
            n++;
         end
         step();
      end
      wdata_valid = 1'b0;
      n = 0;
      while (u_flash_dev_model.busy !== 1'b1 && n < 1000) begin
         step();
         n++;
      end
      // Device programming must hold off new commands
      `CHK(cmd_ready, 1'b0)
      idle_wait();
      `CHK(u_flash_dev_model.nbytes, 256)
      `CHK(u_flash_dev_model.bad, 0)
      `CHK(u_flash_dev_model.toggles > 1, 1'b1)
      `CHK(load_late, 1'b0)
      `CHK(u_flash_dev_model.late, 0)
      read({s, 8'h00}, s[7:0]);
      read({s, 8'hff}, 8'hff ^ s[7:0]);
   endtask : t_program
   task automatic t_stall();
      // Both answers wait in the buffer while the consumer stalls
      send(flash_host_pkg::OP_READ, 19'h00510);
      send(flash_host_pkg::OP_READ, 19'h7ff20);
      repeat (40) step();
      `CHK(ans_valid, 1'b1)
      take(19'h00510, 8'h15);
      take(19'h7ff20, 8'hdf);
   endtask : t_stall
   task automatic t_late();
      int n;
      int k;
      // Stall before the last byte, past the load window
      send(flash_host_pkg::OP_PROGRAM, 19'h7ff00);
      wdata_valid = 1'b1;
      for (k = 0; k < 256; k++) begin
         wdata = k[7:0] ^ 8'hff;
         if (k == 255) begin
            wdata_valid = 1'b0;
            repeat (6100) step();
            `CHK(load_late, 1'b1)
            `CHK(busy, 1'b1)
            wdata_valid = 1'b1;
         end
         n = 0;
         while (wdata_ready !== 1'b1 && n < 1000) begin
            step();
            n++;
         end
         step();
      end
      wdata_valid = 1'b0;
      idle_wait();
      `CHK(u_flash_dev_model.late, 1)
      `CHK(u_flash_dev_model.nbytes, 255)
      `CHK(u_flash_dev_model.toggles > 1, 1'b1)
      `CHK(load_late, 1'b1)
      read(19'h7fffe, 8'h01);
   endtask : t_late
   task automatic test_done();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : test_done
   initial begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd = '{flash_host_pkg::OP_READ, 19'h00000};
      wdata_valid = 1'b0;
      wdata = 8'h00;
      ans_ready = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      reset = 1'b0;
      step();
      t_ident();
      t_program(11'h005);
      t_program(11'h7ff);
      t_stall();
      t_late();
      test_done();
   end
endmodule : flash_host_tb_top
